// File: hw/term_map_pkg.sv
package term_map_pkg;

    localparam int NUM_TERMS = 6;
    localparam int FN_W      = 5;
    localparam int DATA_W    = 32;
    localparam int ADR_W     = 8;
    localparam int IRQ_W     = 2;

    // Option codes
    localparam logic [4:0] OPT_FWD    = 5'h00;
    localparam logic [4:0] OPT_REV    = 5'h01;
    localparam logic [4:0] OPT_SPD0   = 5'h02;
    localparam logic [4:0] OPT_SPD1   = 5'h03;
    localparam logic [4:0] OPT_SPD2   = 5'h04;
    localparam logic [4:0] OPT_SPD3   = 5'h05;
    localparam logic [4:0] OPT_JOG    = 5'h06;
    localparam logic [4:0] OPT_DCB    = 5'h07;
    localparam logic [4:0] OPT_MOT2   = 5'h08;
    localparam logic [4:0] OPT_RAMP2  = 5'h09;
    localparam logic [4:0] OPT_UNUSED = 5'h0a;
    localparam logic [4:0] OPT_COAST  = 5'h0b;
    localparam logic [4:0] OPT_TRIP   = 5'h0c;
    localparam logic [4:0] OPT_RESET  = 5'h12;

    // Register byte offsets
    localparam logic [7:0] OFS_FUNC   = 8'h00;
    localparam logic [7:0] OFS_POL    = 8'h04;
    localparam logic [7:0] OFS_CMD    = 8'h08;
    localparam logic [7:0] OFS_TRIP   = 8'h0c;
    localparam logic [7:0] OFS_STAT   = 8'h10;
    localparam logic [7:0] OFS_MASK   = 8'h14;

    // Field positions
    localparam int CMD_ACTIVE_LSB = 16;
    localparam int TRIP_CODE_LSB  = 8;
    localparam int STAT_TRIP_BIT  = 0;
    localparam int STAT_NC_BIT    = 1;

    // Reset values and trip display code
    localparam logic [29:0] FUNC_RST = {5'h09, 5'h12, 5'h03,
                                        5'h02, 5'h01, 5'h00};
    localparam logic [5:0]  POL_RST  = 6'h00;
    localparam logic [1:0]  MASK_RST = 2'h0;
    localparam logic [7:0]  TRIP_DISPLAY_CODE = 8'h0c;

    typedef struct packed {
        logic       fwd;
        logic       rev;
        logic [3:0] speed;
        logic       jog;
        logic       dcb;
        logic       mot2;
        logic       ramp2;
        logic       coast;
        logic       freset;
    } cmd_s;

endpackage

// File: hw/terminal_role_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module terminal_role_decoder #(
    parameter int NUM_TERMS = 6,
    parameter int FN_W      = 5
) (
    input  wire logic [NUM_TERMS-1:0]      terminals_in,
    input  wire logic [NUM_TERMS*FN_W-1:0] func_sel_in,
    input  wire logic [NUM_TERMS-1:0]      polarity_in,
    output var  term_map_pkg::cmd_s        cmd_out,
    output var  logic [NUM_TERMS-1:0]      active_out,
    output var  logic [NUM_TERMS-1:0]      trip_arm_out
);

    localparam int OPT_N = 1 << FN_W;

    logic [OPT_N-1:0] onehot [NUM_TERMS];
    logic [OPT_N-1:0] any_opt;

    function automatic logic [OPT_N-1:0] code_onehot(
        input logic [FN_W-1:0] code);
        code_onehot       = '0;
        code_onehot[code] = 1'b1;
    endfunction

    // Any option on any terminal; undefined codes simply hit no output
    for (genvar i = 0; i < NUM_TERMS; i++) begin : g_term
        wire [FN_W-1:0] fn = func_sel_in[i*FN_W +: FN_W]; // R1
        assign active_out[i]   = terminals_in[i] ^ polarity_in[i]; // R2
        assign onehot[i]       = active_out[i] ? code_onehot(fn) : '0; // R16
        assign trip_arm_out[i] = (fn == term_map_pkg::OPT_TRIP);
    end

    always_comb begin
        any_opt = '0;
        for (int i = 0; i < NUM_TERMS; i++) begin
            any_opt = any_opt | onehot[i]; // R13
        end
    end

    assign cmd_out.fwd    = any_opt[term_map_pkg::OPT_FWD]; // R3
    assign cmd_out.rev    = any_opt[term_map_pkg::OPT_REV]; // R4
    assign cmd_out.speed  = {any_opt[term_map_pkg::OPT_SPD3],
                             any_opt[term_map_pkg::OPT_SPD2],
                             any_opt[term_map_pkg::OPT_SPD1],
                             any_opt[term_map_pkg::OPT_SPD0]}; // R5
    assign cmd_out.jog    = any_opt[term_map_pkg::OPT_JOG]; // R6
    assign cmd_out.dcb    = any_opt[term_map_pkg::OPT_DCB]; // R7
    assign cmd_out.mot2   = any_opt[term_map_pkg::OPT_MOT2]; // R8
    assign cmd_out.ramp2  = any_opt[term_map_pkg::OPT_RAMP2]; // R9
    assign cmd_out.coast  = any_opt[term_map_pkg::OPT_COAST]; // R10
    assign cmd_out.freset = any_opt[term_map_pkg::OPT_RESET];

endmodule

`default_nettype wire

// File: hw/external_trip_latch.sv
`timescale 1ns/1ps
`default_nettype none

module external_trip_latch #(
    parameter int NUM_TERMS = 6
) (
    input  wire logic                 clk_sys_in,
    input  wire logic                 rstn_in,
    input  wire logic [NUM_TERMS-1:0] active_in,
    input  wire logic [NUM_TERMS-1:0] arm_in,
    input  wire logic                 clear_in,
    output var  logic                 trip_event_out,
    output var  logic                 trip_latched_out
);

    logic                 primed_reg;
    logic [NUM_TERMS-1:0] prev_reg;
    logic                 latched_reg;
    logic                 event_reg;

    // First cycle only loads history, so a level present at reset
    // release is not mistaken for an edge
    wire rise_w = primed_reg & (|(active_in & ~prev_reg & arm_in)); // R11
    wire latched_next = rise_w | (latched_reg & ~clear_in); // R12

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            primed_reg  <= 1'b0;
            prev_reg    <= '0;
            latched_reg <= 1'b0;
            event_reg   <= 1'b0;
        end else begin
            primed_reg  <= 1'b1;
            prev_reg    <= active_in;
            latched_reg <= latched_next;
            event_reg   <= rise_w;
        end
    end

    assign trip_event_out   = event_reg;
    assign trip_latched_out = latched_reg;

    a_trip_on_rise: assert property ( // R11
        @(posedge clk_sys_in) disable iff (!rstn_in)
        rise_w |=> trip_latched_out && trip_event_out)
        else $error("trip not latched on rising edge");

    a_trip_history: assert property ( // R12
        @(posedge clk_sys_in) disable iff (!rstn_in)
        trip_latched_out && !clear_in |=> trip_latched_out)
        else $error("trip history lost without reset");

    a_no_fall_trip: assert property ( // R12
        @(posedge clk_sys_in) disable iff (!rstn_in)
        primed_reg && !trip_latched_out && !(|(active_in & arm_in))
        |=> !trip_latched_out)
        else $error("trip raised without rising edge");

endmodule

`default_nettype wire

// File: hw/input_terminal_function_mapper.sv
// Notes on behaviour
// [R1] Six terminals, each takes the role chosen by its own option code.
// [R2] Per-terminal polarity decides active high or low before decoding.
// [R3] Option 00 active means forward run, inactive means stop.
// [R4] Option 01 active means reverse run, inactive means stop.
// [R5] Options 02 to 05 give speed index bits 0 to 3.
// [R6] Option 06 active runs at jog frequency, inactive means stop.
// [R7] Option 07 active applies DC braking during deceleration.
// [R8] Option 08 active selects the second motor parameter set.
// [R9] Option 09 active selects second-stage ramp values.
// [R10] Option 11 active turns output off so the motor coasts.
// [R11] Option 12 rising active edge latches a trip, showing code 12.
// [R12] Falling edge never trips; latched trip stays until reset.
// [R13] Same option on several terminals gives the OR of them.
// [R14] Polarity defaults to active high, each may be set active low.
// [R15] A terminal holding option 18 can never be active low.
// [R16] Undefined codes such as 10 drive no command at all.
`timescale 1ns/1ps
`default_nettype none

module input_terminal_function_mapper #(
    parameter int NUM_TERMS = 6
) (
    input  wire logic                 clk_sys_in,
    input  wire logic                 rstn_in,
    input  wire logic [NUM_TERMS-1:0] terminals_in,
    input  wire logic                 wb_cyc_in,
    input  wire logic                 wb_stb_in,
    input  wire logic                 wb_we_in,
    input  wire logic [7:0]           wb_adr_in,
    input  wire logic [3:0]           wb_sel_in,
    input  wire logic [31:0]          wb_dat_in,
    output var  logic [31:0]          wb_dat_out,
    output var  logic                 wb_ack_out,
    output var  logic                 forward_run_cmd_out,
    output var  logic                 reverse_run_cmd_out,
    output var  logic [3:0]           speed_index_out,
    output var  logic                 jog_cmd_out,
    output var  logic                 dc_brake_cmd_out,
    output var  logic                 second_motor_sel_out,
    output var  logic                 dual_ramp_select_out,
    output var  logic                 coast_stop_cmd_out,
    output var  logic                 fault_reset_cmd_out,
    output var  logic                 external_trip_out,
    output var  logic [7:0]           external_trip_display_code_out,
    output var  logic                 irq_out
);

    localparam int FN_W  = term_map_pkg::FN_W;
    localparam int SEL_W = NUM_TERMS * FN_W;

    function automatic logic [NUM_TERMS-1:0] reset_mask(
        input logic [SEL_W-1:0] fsel);
        for (int i = 0; i < NUM_TERMS; i++) begin
            reset_mask[i] = (fsel[i*FN_W +: FN_W] == term_map_pkg::OPT_RESET);
        end
    endfunction

    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  sel);
        for (int b = 0; b < 4; b++) begin
            lane_merge[b*8 +: 8] = sel[b] ? new_val[b*8 +: 8]
                                          : old_val[b*8 +: 8];
        end
    endfunction

    logic [SEL_W-1:0]                   func_reg;
    logic [NUM_TERMS-1:0]               pol_reg;
    logic [term_map_pkg::IRQ_W-1:0]     stat_reg;
    logic [term_map_pkg::IRQ_W-1:0]     mask_reg;
    logic                               ack_reg;
    logic [31:0]                        dat_reg;
    term_map_pkg::cmd_s                 cmd_reg;
    logic [7:0]                         code_reg;
    logic                               irq_reg;

    term_map_pkg::cmd_s                 cmd_w;
    logic [NUM_TERMS-1:0]               active_w;
    logic [NUM_TERMS-1:0]               arm_w;
    logic                               trip_evt_w;
    logic                               trip_lat_w;

    // Bus decode: one wait state, every access acknowledged
    wire req_w      = wb_cyc_in & wb_stb_in & ~ack_reg;
    // Writes land at the ack edge, once the master has seen the answer
    wire wr_w       = wb_cyc_in & wb_stb_in & wb_we_in & ack_reg;
    wire sel_func_w = (wb_adr_in[7:2] == term_map_pkg::OFS_FUNC[7:2]);
    wire sel_pol_w  = (wb_adr_in[7:2] == term_map_pkg::OFS_POL[7:2]);
    wire sel_cmd_w  = (wb_adr_in[7:2] == term_map_pkg::OFS_CMD[7:2]);
    wire sel_trip_w = (wb_adr_in[7:2] == term_map_pkg::OFS_TRIP[7:2]);
    wire sel_stat_w = (wb_adr_in[7:2] == term_map_pkg::OFS_STAT[7:2]);
    wire sel_mask_w = (wb_adr_in[7:2] == term_map_pkg::OFS_MASK[7:2]);

    wire [31:0] func_wide_w = {{(32-SEL_W){1'b0}}, func_reg};
    wire [31:0] pol_wide_w  = {{(32-NUM_TERMS){1'b0}}, pol_reg};
    wire [31:0] mask_wide_w = {30'h0, mask_reg};

    wire [31:0] func_mrg_w = lane_merge(func_wide_w, wb_dat_in, wb_sel_in);
    wire [31:0] pol_mrg_w  = lane_merge(pol_wide_w, wb_dat_in, wb_sel_in);
    wire [31:0] mask_mrg_w = lane_merge(mask_wide_w, wb_dat_in, wb_sel_in);

    wire [SEL_W-1:0] func_next =
        (wr_w & sel_func_w) ? func_mrg_w[SEL_W-1:0] : func_reg; // R1
    wire [NUM_TERMS-1:0] pol_cand_w =
        (wr_w & sel_pol_w) ? pol_mrg_w[NUM_TERMS-1:0] : pol_reg; // R14
    // Reset-role terminals are forced back to active high on any write
    wire [NUM_TERMS-1:0] rst_role_w = reset_mask(func_next);
    wire [NUM_TERMS-1:0] pol_next   = pol_cand_w & ~rst_role_w; // R15
    wire nc_refused_w = wr_w & (sel_pol_w | sel_func_w)
                      & (|(pol_cand_w & rst_role_w));

    wire [term_map_pkg::IRQ_W-1:0] mask_next =
        (wr_w & sel_mask_w) ? mask_mrg_w[term_map_pkg::IRQ_W-1:0]
                            : mask_reg;

    // Write-one-to-clear; a new event in the same cycle wins
    wire [term_map_pkg::IRQ_W-1:0] stat_clr_w =
        (wr_w & sel_stat_w & wb_sel_in[0])
            ? wb_dat_in[term_map_pkg::IRQ_W-1:0] : '0;
    wire [term_map_pkg::IRQ_W-1:0] stat_set_w = {nc_refused_w, trip_evt_w};
    wire [term_map_pkg::IRQ_W-1:0] stat_next =
        stat_set_w | (stat_reg & ~stat_clr_w);

    wire sw_trip_clr_w = wr_w & sel_trip_w & wb_sel_in[0] & wb_dat_in[0];
    wire trip_clr_w    = sw_trip_clr_w | cmd_w.freset; // R12

    wire [7:0] code_next =
        trip_lat_w ? term_map_pkg::TRIP_DISPLAY_CODE : 8'h00; // R11

    wire [31:0] rd_cmd_w  = {{(16-NUM_TERMS){1'b0}}, active_w,
                             4'h0, cmd_w};
    wire [31:0] rd_trip_w = {16'h0, code_reg, 7'h0, trip_lat_w};
    wire [31:0] rd_w = sel_func_w ? func_wide_w
                     : sel_pol_w  ? pol_wide_w
                     : sel_cmd_w  ? rd_cmd_w
                     : sel_trip_w ? rd_trip_w
                     : sel_stat_w ? {30'h0, stat_reg}
                     : sel_mask_w ? mask_wide_w
                     : 32'h0;

    terminal_role_decoder #(
        .NUM_TERMS (NUM_TERMS),
        .FN_W      (FN_W)
    ) u_decode (
        .terminals_in (terminals_in),
        .func_sel_in  (func_reg),
        .polarity_in  (pol_reg),
        .cmd_out      (cmd_w),
        .active_out   (active_w),
        .trip_arm_out (arm_w)
    );

    external_trip_latch #(
        .NUM_TERMS (NUM_TERMS)
    ) u_trip (
        .clk_sys_in       (clk_sys_in),
        .rstn_in          (rstn_in),
        .active_in        (active_w),
        .arm_in           (arm_w),
        .clear_in         (trip_clr_w),
        .trip_event_out   (trip_evt_w),
        .trip_latched_out (trip_lat_w)
    );

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            func_reg <= term_map_pkg::FUNC_RST;
            pol_reg  <= term_map_pkg::POL_RST;
            mask_reg <= term_map_pkg::MASK_RST;
            stat_reg <= '0;
            ack_reg  <= 1'b0;
            dat_reg  <= 32'h0;
        end else begin
            func_reg <= func_next;
            pol_reg  <= pol_next;
            mask_reg <= mask_next;
            stat_reg <= stat_next;
            ack_reg  <= req_w;
            if (req_w) begin
                dat_reg <= rd_w;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmd_reg  <= '0;
            code_reg <= 8'h00;
            irq_reg  <= 1'b0;
        end else begin
            cmd_reg  <= cmd_w;
            code_reg <= code_next;
            irq_reg  <= |(stat_next & mask_next);
        end
    end

    assign wb_ack_out                     = ack_reg;
    assign wb_dat_out                     = dat_reg;
    assign forward_run_cmd_out            = cmd_reg.fwd;
    assign reverse_run_cmd_out            = cmd_reg.rev;
    assign speed_index_out                = cmd_reg.speed;
    assign jog_cmd_out                    = cmd_reg.jog;
    assign dc_brake_cmd_out               = cmd_reg.dcb;
    assign second_motor_sel_out           = cmd_reg.mot2;
    assign dual_ramp_select_out           = cmd_reg.ramp2;
    assign coast_stop_cmd_out             = cmd_reg.coast;
    assign fault_reset_cmd_out            = cmd_reg.freset;
    assign external_trip_out              = trip_lat_w;
    assign external_trip_display_code_out = code_reg;
    assign irq_out                        = irq_reg;

    // Independent references for the checks below
    logic [NUM_TERMS-1:0] fwd_hit_w;
    logic [NUM_TERMS-1:0] undef_w;
    for (genvar i = 0; i < NUM_TERMS; i++) begin : g_ref
        wire [FN_W-1:0] fn = func_reg[i*FN_W +: FN_W];
        assign fwd_hit_w[i] = active_w[i] & (fn == term_map_pkg::OPT_FWD);
        assign undef_w[i]   = (fn == term_map_pkg::OPT_UNUSED);
    end

    a_polarity_apply: assert property ( // R2
        @(posedge clk_sys_in) disable iff (!rstn_in)
        active_w == (terminals_in ^ pol_reg))
        else $error("terminal polarity not applied");

    a_fwd_follow: assert property ( // R3
        @(posedge clk_sys_in) disable iff (!rstn_in)
        ##1 forward_run_cmd_out == $past(|fwd_hit_w))
        else $error("forward run does not follow terminals");

    a_rev_follow: assert property ( // R4
        @(posedge clk_sys_in) disable iff (!rstn_in)
        !cmd_w.rev |=> !reverse_run_cmd_out)
        else $error("reverse run without active terminal");

    a_speed_index: assert property ( // R5
        @(posedge clk_sys_in) disable iff (!rstn_in)
        ##1 speed_index_out == $past(cmd_w.speed))
        else $error("speed index mismatch");

    a_jog_follow: assert property ( // R6
        @(posedge clk_sys_in) disable iff (!rstn_in)
        cmd_w.jog |=> jog_cmd_out)
        else $error("jog command missed");

    a_brake_follow: assert property ( // R7
        @(posedge clk_sys_in) disable iff (!rstn_in)
        $rose(cmd_w.dcb) |=> $rose(dc_brake_cmd_out))
        else $error("dc brake command late");

    a_motor2_sel: assert property ( // R8
        @(posedge clk_sys_in) disable iff (!rstn_in)
        !cmd_w.mot2 |=> !second_motor_sel_out)
        else $error("second motor set without command");

    a_ramp2_sel: assert property ( // R9
        @(posedge clk_sys_in) disable iff (!rstn_in)
        cmd_w.ramp2 |=> dual_ramp_select_out)
        else $error("second ramp select missed");

    a_coast_stop: assert property ( // R10
        @(posedge clk_sys_in) disable iff (!rstn_in)
        ##1 coast_stop_cmd_out == $past(cmd_w.coast))
        else $error("coast stop mismatch");

    a_trip_code: assert property ( // R11
        @(posedge clk_sys_in) disable iff (!rstn_in)
        trip_lat_w |=> external_trip_display_code_out
                        == term_map_pkg::TRIP_DISPLAY_CODE)
        else $error("trip display code missing");

    a_or_merge: assert property ( // R13
        @(posedge clk_sys_in) disable iff (!rstn_in)
        cmd_w.fwd == (|fwd_hit_w))
        else $error("shared option not ORed");

    a_reset_no_nc: assert property ( // R15
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (pol_reg & reset_mask(func_reg)) == '0)
        else $error("reset role set active low");

    a_undef_idle: assert property ( // R16
        @(posedge clk_sys_in) disable iff (!rstn_in)
        &undef_w |=> cmd_reg == '0)
        else $error("undefined option drove a command");

    a_irq_level: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        ##1 irq_out == (|(stat_reg & mask_reg)))
        else $error("interrupt level mismatch");

endmodule

`default_nettype wire

// File: verif/term_contacts.sv
`timescale 1ns/1ps
`default_nettype none

module term_contacts (
    input  wire logic       clk_sys_in,
    input  wire logic [5:0] level_in,
    output var  logic [5:0] terminals_out
);
    // Contacts move just after an edge, never mid-cycle
    initial terminals_out = 6'h00;
    always @(posedge clk_sys_in) begin
        terminals_out <= level_in;
    end
endmodule

`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        clk_sys_in = 1'b0;
    logic        rstn_in    = 1'b0;
    logic [5:0]  want       = 6'h00;
    logic        cyc        = 1'b0;
    logic        we         = 1'b0;
    logic [7:0]  adr        = 8'h00;
    logic [31:0] wdat       = 32'h0;
    wire  [5:0]  terms;
    wire  [31:0] rdat;
    wire         ack;
    wire  [11:0] cmd;
    wire         trip;
    wire  [7:0]  code;
    wire         irq;
    logic [29:0] fsel;
    logic [5:0]  pol;
    logic [5:0]  act;
    logic [31:0] q;
    logic [4:0]  opts [14] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
        5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h12, 5'h0d};
    int          error_cnt  = 0;
    int          cmp_count  = 0;

    always #5 clk_sys_in = ~clk_sys_in;

    term_contacts i_term_contacts (.clk_sys_in(clk_sys_in),
        .level_in(want), .terminals_out(terms));

    input_terminal_function_mapper i_input_terminal_function_mapper (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .terminals_in(terms),
        .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .forward_run_cmd_out(cmd[11]),
        .reverse_run_cmd_out(cmd[10]), .speed_index_out(cmd[9:6]),
        .jog_cmd_out(cmd[5]), .dc_brake_cmd_out(cmd[4]),
        .second_motor_sel_out(cmd[3]), .dual_ramp_select_out(cmd[2]),
        .coast_stop_cmd_out(cmd[1]), .fault_reset_cmd_out(cmd[0]),
        .external_trip_out(trip), .external_trip_display_code_out(code),
        .irq_out(irq));

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Classic single cycle; waits for ack, never assumes a latency
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge clk_sys_in);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        we  <= 1'b0;
        if (n >= 20) begin
            chk(32'h1, 32'h0);
            end_sim();
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    function automatic int bit_of(input logic [4:0] c);
        if (c <= 5'h01) return 11 - int'(c);
        if (c <= 5'h05) return 4 + int'(c);
        if (c <= 5'h09) return 11 - int'(c);
        if (c == 5'h0b) return 1;
        if (c == 5'h12) return 0;
        return -1;
    endfunction

    // Reference decode from the bench's own copy of the settings
    task automatic check_cmd();
        logic [11:0] e;
        logic [5:0]  pe;
        int          b;
        e = 12'h0;
        for (int i = 0; i < 6; i++) begin
            pe[i] = pol[i] && fsel[5*i+:5] != term_map_pkg::OPT_RESET;
            act[i] = want[i] ^ pe[i];
            b = bit_of(fsel[5*i+:5]);
            if (b >= 0) e[b] = e[b] | act[i];
        end
        repeat (4) @(posedge clk_sys_in);
        chk({20'h0, cmd}, {20'h0, e});
        rchk(term_map_pkg::OFS_POL, {26'h0, pe});
        rchk(term_map_pkg::OFS_CMD, {10'h0, act, 4'h0, e});
    endtask

    initial begin
        void'($urandom(32'h6662));
        repeat (20) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        rchk(term_map_pkg::OFS_FUNC, {2'b0, term_map_pkg::FUNC_RST});
        rchk(term_map_pkg::OFS_POL, 32'h0);
        rchk(term_map_pkg::OFS_MASK, 32'h0);
        rchk(8'h20, 32'h0);
        $display("test reset values done");
        for (int k = 0; k < 40; k++) begin
            for (int i = 0; i < 6; i++) fsel[5*i+:5] = opts[$urandom % 14];
            pol = 6'($urandom);
            want <= 6'($urandom);
            wb(1'b1, term_map_pkg::OFS_FUNC, {2'b0, fsel});
            wb(1'b1, term_map_pkg::OFS_POL, {26'h0, pol});
            check_cmd();
        end
        $display("test random mapping done");
        fsel = {6{5'h0a}};
        want <= 6'h3f;
        wb(1'b1, term_map_pkg::OFS_FUNC, {2'b0, fsel});
        repeat (4) @(posedge clk_sys_in);
        chk({20'h0, cmd}, 32'h0);
        $display("test undefined options done");
        fsel = {{5{5'h0a}}, 5'h0c};
        want <= 6'h00;
        wb(1'b1, term_map_pkg::OFS_FUNC, {2'b0, fsel});
        wb(1'b1, term_map_pkg::OFS_POL, 32'h0);
        wb(1'b1, term_map_pkg::OFS_MASK, 32'h1);
        wb(1'b1, term_map_pkg::OFS_TRIP, 32'h1);
        wb(1'b1, term_map_pkg::OFS_STAT, 32'h3);
        chk({29'h0, trip, irq, code == 8'h00}, 32'h1);
        want <= 6'h01;
        repeat (4) @(posedge clk_sys_in);
        chk({22'h0, trip, irq, code}, {22'h0, 1'b1, 1'b1, 8'h0c});
        rchk(term_map_pkg::OFS_STAT, 32'h1);
        want <= 6'h00;
        repeat (4) @(posedge clk_sys_in);
        chk({31'h0, trip}, 32'h1);
        wb(1'b1, term_map_pkg::OFS_STAT, 32'h1);
        repeat (2) @(posedge clk_sys_in);
        chk({30'h0, trip, irq}, 32'h2);
        wb(1'b1, term_map_pkg::OFS_TRIP, 32'h1);
        repeat (2) @(posedge clk_sys_in);
        chk({23'h0, trip, code}, 32'h0);
        // Inverting the sense makes the idle contact active: a new edge
        wb(1'b1, term_map_pkg::OFS_POL, 32'h1);
        repeat (4) @(posedge clk_sys_in);
        chk({31'h0, trip}, 32'h1);
        wb(1'b1, term_map_pkg::OFS_TRIP, 32'h1);
        want <= 6'h01;
        repeat (4) @(posedge clk_sys_in);
        chk({31'h0, trip}, 32'h0);
        $display("test external trip done");
        end_sim();
    end
endmodule

`default_nettype wire
